// ---- hw/irq_pkg.sv ----
package irq_pkg;

  localparam int          ADDR_W     = 3;
  localparam int          DATA_W     = 8;
  localparam int          NUM_SRC    = 8;
  localparam int          NUM_PIN    = 2;
  localparam int          NUM_PORT   = 4;
  localparam int          NUM_PERIPH = 5;
  localparam int          PC_W       = 16;

  // Register offsets on the plain register port.
  localparam logic [2:0]  OFF_MAIN_CTRL  = 3'h0;
  localparam logic [2:0]  OFF_RESET_CTRL = 3'h1;
  localparam logic [2:0]  OFF_SRC_ENABLE = 3'h2;
  localparam logic [2:0]  OFF_SRC_PRIO   = 3'h3;
  localparam logic [2:0]  OFF_SRC_FLAG   = 3'h4;
  localparam logic [2:0]  OFF_STATUS     = 3'h5;
  localparam logic [2:0]  OFF_EDGE_SEL   = 3'h6;
  localparam logic [2:0]  OFF_PORT_VAL   = 3'h7;

  // Field positions.
  localparam int          BIT_GLOBAL_HIGH  = 7;
  localparam int          BIT_GLOBAL_LOW   = 6;
  localparam int          BIT_PRIO_SCHEME  = 7;
  localparam int          BIT_SERV_HIGH    = 1;
  localparam int          BIT_SERV_LOW     = 0;
  localparam int          BIT_PRIO_ACTIVE  = 7;
  localparam int          SRC_PIN0         = 0;
  localparam int          SRC_PORT_CHANGE  = 2;
  localparam int          SRC_PERIPH0      = 3;

  // Sources 0..2 are core sources; the rest form the peripheral group.
  localparam logic [7:0]  CORE_SRC_MASK  = 8'h07;

  // Reset values.
  localparam logic [7:0]  RST_ENABLE     = 8'h00;
  localparam logic [7:0]  RST_PRIO       = 8'hFF;
  localparam logic [7:0]  RST_FLAG       = 8'h00;
  localparam logic [1:0]  RST_EDGE_SEL   = 2'h3;
  localparam logic [7:0]  READ_ZERO      = 8'h00;

  // Fixed service entry addresses.
  localparam logic [15:0] VEC_HIGH       = 16'h0008;
  localparam logic [15:0] VEC_LOW        = 16'h0018;

  // Cycles from an external edge to the vector pulse.
  localparam int          EXT_LAT_MIN    = 3;
  localparam int          EXT_LAT_MAX    = 4;

endpackage

// ---- hw/pin_sync_edge.sv ----
module pin_sync_edge #(
  parameter int W = 2
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic [W-1:0] raw,
  input  wire logic [W-1:0] rise_sel,
  output logic      [W-1:0] level,
  output logic      [W-1:0] edge_pulse
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [W-1:0] prev_q;

  // Only sync_q looks at meta_q; everything downstream uses the second stage.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= raw;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_edge
      assign edge_pulse[i] = rise_sel[i] ? (sync_q[i] & ~prev_q[i]) : (~sync_q[i] & prev_q[i]);
    end
  endgenerate

  assign level = sync_q;

endmodule // pin_sync_edge

// ---- hw/flag_bank.sv ----
module flag_bank #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic [W-1:0] set,
  input  wire logic         wr_en,
  input  wire logic [W-1:0] wr_data,
  output logic      [W-1:0] flags_q
);

  logic [W-1:0] flags_d;

  // A hardware event in the same cycle as a software clear still leaves the flag set.
  always_comb begin
    flags_d = wr_en ? wr_data : flags_q;
    flags_d = flags_d | set;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      flags_q <= irq_pkg::RST_FLAG;
    end else begin
      flags_q <= flags_d;
    end
  end

endmodule // flag_bank

// ---- hw/two_level_interrupt_controller.sv ----
// Function
// - Two fixed service addresses: 0008h for high, 0018h for low priority.
// - High requests preempt low service; low requests wait during high service.
// - Source flags set on every event, regardless of any enable bit.
// - Priority operation runs only while reset control bit 7 is set.
// - Priority mode: bit 7 gates high sources, bit 6 gates low sources.
// - Flag, enable, bit 7 and any matching bit 6 set means vectoring at once; low sources also wait out high service.
// - Priority mode is off after reset; priority bits then do nothing.
// - Compatibility mode: bit 6 gates peripheral group, bit 7 gates all.
// - Compatibility mode sends every accepted request to 0008h.
// - Accepting a request clears the global enable that admitted it.
// - On acceptance the core pushes its return address and loads the vector.
// - Return from service sets again the global enable cleared on entry.
// - External pin and port change events vector within three to four cycles.
// - External latency is the same for one- and two-cycle instructions.
// - Clearing one source enable blocks only that source.
// - Priority mode: low enable admits only low sources; high clear blocks all.
//
// Implementation choices: the register offsets and the plain strobed port.
module two_level_interrupt_controller (
  input  wire logic        CLK,
  input  wire logic        RESET,
  input  wire logic [2:0]  ADDR,
  input  wire logic [7:0]  WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [7:0]  RDATA,
  input  wire logic [1:0]  EXT_PIN,
  input  wire logic [3:0]  CHANGE_PORT,
  input  wire logic [4:0]  PERIPH_EVENT,
  input  wire logic        RETURN_INSTR,
  output logic             VEC_TAKE,
  output logic             STACK_PUSH,
  output logic      [15:0] VEC_ADDR,
  output logic             SERV_HIGH,
  output logic             SERV_LOW
);

  logic [7:0]  rdata_q;
  logic        take_q;
  logic [15:0] vec_addr_q;
  logic        global_high_enable_q;
  logic        global_low_enable_q;
  logic        priority_scheme_enable_q;
  logic [7:0]  src_enable_q;
  logic [7:0]  src_prio_q;
  logic [1:0]  edge_sel_q;
  logic [3:0]  port_last_q;
  logic        serv_high_q;
  logic        serv_low_q;
  logic [7:0]  flags;
  logic [7:0]  src_set;
  logic [1:0]  pin_level;
  logic [1:0]  pin_edge;
  logic [3:0]  port_level;
  logic [7:0]  pending;
  logic        high_elig;
  logic        low_elig;
  logic        acc_high;
  logic        acc_low;
  logic        flag_wr;

  function automatic logic reg_hit(input logic [2:0] addr, input logic [2:0] off);
    reg_hit = (addr == off);
  endfunction

  pin_sync_edge #(
    .W (irq_pkg::NUM_PIN)
  ) u_pin_sync (
    .clk        (CLK),
    .reset      (RESET),
    .raw        (EXT_PIN),
    .rise_sel   (edge_sel_q),
    .level      (pin_level),
    .edge_pulse (pin_edge)
  );

  pin_sync_edge #(
    .W (irq_pkg::NUM_PORT)
  ) u_port_sync (
    .clk        (CLK),
    .reset      (RESET),
    .raw        (CHANGE_PORT),
    .rise_sel   ('1),
    .level      (port_level),
    .edge_pulse ()
  );

  // A mismatch against the last read keeps setting the change flag until the port is read.
  assign src_set = {PERIPH_EVENT, (port_level != port_last_q), pin_edge};
  assign flag_wr = WR && reg_hit(ADDR, irq_pkg::OFF_SRC_FLAG);

  flag_bank #(
    .W (irq_pkg::NUM_SRC)
  ) u_flags (
    .clk     (CLK),
    .reset   (RESET),
    .set     (src_set),
    .wr_en   (flag_wr),
    .wr_data (WDATA),
    .flags_q (flags)
  );

  // Delivery needs no instruction boundary, so latency does not depend on instruction length.
  always_comb begin
    pending   = flags & src_enable_q;
    high_elig = 1'b0;
    low_elig  = 1'b0;
    if (priority_scheme_enable_q) begin
      high_elig = |(pending & src_prio_q) && global_high_enable_q;
      low_elig  = |(pending & ~src_prio_q) && global_low_enable_q && global_high_enable_q && !serv_high_q;
    end else begin
      high_elig = |(pending & (irq_pkg::CORE_SRC_MASK | {8{global_low_enable_q}})) && global_high_enable_q;
    end
    acc_high = high_elig;
    acc_low  = low_elig && !high_elig;
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      take_q     <= 1'b0;
      vec_addr_q <= irq_pkg::VEC_HIGH;
    end else begin
      take_q <= acc_high || acc_low;
      if (acc_high) begin
        vec_addr_q <= irq_pkg::VEC_HIGH;
      end else if (acc_low) begin
        vec_addr_q <= irq_pkg::VEC_LOW;
      end
    end
  end

  // Acceptance beats a software write to the same enable in the same cycle.
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      global_high_enable_q <= 1'b0;
      global_low_enable_q  <= 1'b0;
    end else begin
      if (WR && reg_hit(ADDR, irq_pkg::OFF_MAIN_CTRL)) begin
        global_high_enable_q <= WDATA[irq_pkg::BIT_GLOBAL_HIGH];
        global_low_enable_q  <= WDATA[irq_pkg::BIT_GLOBAL_LOW];
      end
      if (RETURN_INSTR) begin
        if (priority_scheme_enable_q && !serv_high_q && serv_low_q) begin
          global_low_enable_q <= 1'b1;
        end else begin
          global_high_enable_q <= 1'b1;
        end
      end
      if (acc_high) begin
        global_high_enable_q <= 1'b0;
      end else if (acc_low) begin
        global_low_enable_q <= 1'b0;
      end
    end
  end

  // Service levels; the innermost level ends first on return.
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      serv_high_q <= 1'b0;
      serv_low_q  <= 1'b0;
    end else begin
      if (RETURN_INSTR) begin
        if (serv_high_q) begin
          serv_high_q <= 1'b0;
        end else begin
          serv_low_q <= 1'b0;
        end
      end
      if (acc_high) begin
        serv_high_q <= 1'b1;
      end
      if (acc_low) begin
        serv_low_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      priority_scheme_enable_q <= 1'b0;
      src_enable_q             <= irq_pkg::RST_ENABLE;
      src_prio_q               <= irq_pkg::RST_PRIO;
      edge_sel_q               <= irq_pkg::RST_EDGE_SEL;
    end else if (WR) begin
      case (ADDR)
        irq_pkg::OFF_RESET_CTRL: begin
          priority_scheme_enable_q <= WDATA[irq_pkg::BIT_PRIO_SCHEME];
        end
        irq_pkg::OFF_SRC_ENABLE: begin
          src_enable_q <= WDATA;
        end
        irq_pkg::OFF_SRC_PRIO: begin
          src_prio_q <= WDATA;
        end
        irq_pkg::OFF_EDGE_SEL: begin
          edge_sel_q <= WDATA[1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Reading the port value ends a change mismatch.
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      port_last_q <= 4'h0;
    end else if (RD && reg_hit(ADDR, irq_pkg::OFF_PORT_VAL)) begin
      port_last_q <= port_level;
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      rdata_q <= irq_pkg::READ_ZERO;
    end else if (RD) begin
      case (ADDR)
        irq_pkg::OFF_MAIN_CTRL:  rdata_q <= {global_high_enable_q, global_low_enable_q, 6'h00};
        irq_pkg::OFF_RESET_CTRL: rdata_q <= {priority_scheme_enable_q, 7'h00};
        irq_pkg::OFF_SRC_ENABLE: rdata_q <= src_enable_q;
        irq_pkg::OFF_SRC_PRIO:   rdata_q <= src_prio_q;
        irq_pkg::OFF_SRC_FLAG:   rdata_q <= flags;
        irq_pkg::OFF_STATUS:     rdata_q <= {priority_scheme_enable_q, 5'h00, serv_high_q, serv_low_q};
        irq_pkg::OFF_EDGE_SEL:   rdata_q <= {6'h00, edge_sel_q};
        irq_pkg::OFF_PORT_VAL:   rdata_q <= {2'h0, pin_level, port_level};
        default:                 rdata_q <= irq_pkg::READ_ZERO;
      endcase
    end else begin
      rdata_q <= irq_pkg::READ_ZERO;
    end
  end

  assign RDATA      = rdata_q;
  assign VEC_TAKE   = take_q;
  assign STACK_PUSH = take_q;
  assign VEC_ADDR   = vec_addr_q;
  assign SERV_HIGH  = serv_high_q;
  assign SERV_LOW   = serv_low_q;

  sequence pin0_event_s;
    pin_edge[irq_pkg::SRC_PIN0] && src_enable_q[irq_pkg::SRC_PIN0] && !priority_scheme_enable_q
      && global_high_enable_q && !take_q && !flag_wr && !RETURN_INSTR;
  endsequence

  sequence high_take_s;
    take_q && (vec_addr_q == irq_pkg::VEC_HIGH);
  endsequence

  sequence low_take_s;
    take_q && (vec_addr_q == irq_pkg::VEC_LOW);
  endsequence

  vector_pair_a: assert property (@(posedge CLK) disable iff (RESET)
    take_q |-> (vec_addr_q == irq_pkg::VEC_HIGH) || (vec_addr_q == irq_pkg::VEC_LOW))
    else $error("vector address is neither service entry");

  compat_vector_a: assert property (@(posedge CLK) disable iff (RESET)
    take_q && !priority_scheme_enable_q && !$past(priority_scheme_enable_q) |-> vec_addr_q == irq_pkg::VEC_HIGH)
    else $error("compatibility mode used the low entry");

  low_blocked_a: assert property (@(posedge CLK) disable iff (RESET)
    take_q && (vec_addr_q == irq_pkg::VEC_LOW) |-> !$past(serv_high_q))
    else $error("low request taken during high service");

  preempt_low_a: assert property (@(posedge CLK) disable iff (RESET)
    serv_low_q && high_elig && !serv_high_q |=> high_take_s ##1 serv_high_q && !global_high_enable_q)
    else $error("high request did not preempt low service");

  enable_clear_a: assert property (@(posedge CLK) disable iff (RESET)
    high_take_s |-> !global_high_enable_q)
    else $error("admitting enable still set after high entry");

  flag_sets_a: assert property (@(posedge CLK) disable iff (RESET)
    |src_set |=> (flags & $past(src_set)) == $past(src_set))
    else $error("source event did not set its flag");

  return_enable_a: assert property (@(posedge CLK) disable iff (RESET)
    RETURN_INSTR && serv_high_q && !acc_high |=> global_high_enable_q && !serv_high_q)
    else $error("return did not restore the high enable");

  source_gate_a: assert property (@(posedge CLK) disable iff (RESET)
    take_q |-> $past(pending) != 8'h00)
    else $error("vector taken with no enabled pending source");

  ext_latency_a: assert property (@(posedge CLK) disable iff (RESET)
    pin0_event_s |-> ##[1:2] high_take_s)
    else $error("external event missed its latency window");

  high_first_a: assert property (@(posedge CLK) disable iff (RESET)
    high_elig && low_elig |=> high_take_s)
    else $error("low request won over a simultaneous high one");

  // In compatibility mode a core source with the single enable set is taken on the next edge.
  accept_now_a: assert property (@(posedge CLK) disable iff (RESET)
    !priority_scheme_enable_q && global_high_enable_q && ((pending & irq_pkg::CORE_SRC_MASK) != 8'h00)
      |=> high_take_s)
    else $error("enabled core source was not taken at once");

  high_gate_a: assert property (@(posedge CLK) disable iff (RESET)
    !global_high_enable_q |=> !take_q)
    else $error("vector taken with the high enable clear");

  periph_gate_a: assert property (@(posedge CLK) disable iff (RESET)
    !priority_scheme_enable_q && !global_low_enable_q && ((pending & irq_pkg::CORE_SRC_MASK) == 8'h00)
      |=> !take_q)
    else $error("peripheral source taken with its group gate clear");

  low_gate_a: assert property (@(posedge CLK) disable iff (RESET)
    priority_scheme_enable_q && !global_low_enable_q && ((pending & src_prio_q) == 8'h00) |=> !take_q)
    else $error("low source taken with the low enable clear");

  compat_level_a: assert property (@(posedge CLK) disable iff (RESET)
    !priority_scheme_enable_q && !serv_low_q |=> !serv_low_q)
    else $error("low service started in compatibility mode");

  high_level_a: assert property (@(posedge CLK) disable iff (RESET)
    high_take_s |-> serv_high_q)
    else $error("high entry did not mark high service");

  low_level_a: assert property (@(posedge CLK) disable iff (RESET)
    low_take_s |-> serv_low_q)
    else $error("low entry did not mark low service");

  low_clear_a: assert property (@(posedge CLK) disable iff (RESET)
    low_take_s |-> !global_low_enable_q)
    else $error("admitting enable still set after low entry");

  return_low_a: assert property (@(posedge CLK) disable iff (RESET)
    RETURN_INSTR && priority_scheme_enable_q && !serv_high_q && serv_low_q && !acc_low
      |=> global_low_enable_q && !serv_low_q)
    else $error("return did not restore the low enable");

  flag_hold_a: assert property (@(posedge CLK) disable iff (RESET)
    !flag_wr |=> (flags & $past(flags)) == $past(flags))
    else $error("request flag dropped without a software write");

  // Two register stages sit between a pin and its level, so the level trails the pin by two edges.
  sync_path_a: assert property (@(posedge CLK) disable iff (RESET)
    !$past(RESET) && !$past(RESET, 2)
      |-> (pin_level == $past(EXT_PIN, 2)) && (port_level == $past(CHANGE_PORT, 2)))
    else $error("pin level does not trail its input by two edges");

endmodule // two_level_interrupt_controller

// ---- bench/core_model.sv ----
// Fetch and stack side of the core: it pushes on every accepted vector and pops on a return.
module core_model (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        vec_take,
  input  wire logic        stack_push,
  input  wire logic [15:0] vec_addr,
  input  wire logic        ret_cmd,
  output logic             return_instr,
  output logic      [15:0] pc_q
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [15:0] stack_q [$];

  // The return is registered, so it reaches the controller one cycle after it is commanded.
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      return_instr <= 1'b0;
    end else begin
      return_instr <= ret_cmd;
    end
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      stack_q.delete();
      pc_q <= 16'h0100;
    end else if (vec_take && stack_push) begin
      stack_q.push_back(pc_q);
      pc_q <= vec_addr;
    end else if (return_instr && stack_q.size() > 0) begin
      pc_q <= stack_q.pop_back();
    end else begin
      pc_q <= pc_q + 16'h0001;
    end
  end
endmodule // core_model

// ---- bench/two_level_interrupt_controller_test.sv ----
module two_level_interrupt_controller_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic        CLK = 1'b0;
  logic        RESET = 1'b1;
  logic [2:0]  ADDR = 3'h0;
  logic [7:0]  WDATA = 8'h00;
  logic        WR = 1'b0;
  logic        RD = 1'b0;
  logic [1:0]  EXT_PIN = 2'h0;
  logic [3:0]  CHANGE_PORT = 4'h0;
  logic [4:0]  PERIPH_EVENT = 5'h00;
  logic        ret_cmd = 1'b0;
  logic        RETURN_INSTR, VEC_TAKE, STACK_PUSH, SERV_HIGH, SERV_LOW;
  logic [7:0]  RDATA;
  logic [15:0] VEC_ADDR, pc;
  logic [7:0]  rst_v [7] = '{8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h03};
  int          err_count = 0;
  int          samples_checked = 0;
  int          n;

  always #5 CLK = ~CLK;

  two_level_interrupt_controller DUT (.CLK(CLK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .EXT_PIN(EXT_PIN), .CHANGE_PORT(CHANGE_PORT), .PERIPH_EVENT(PERIPH_EVENT),
    .RETURN_INSTR(RETURN_INSTR), .VEC_TAKE(VEC_TAKE), .STACK_PUSH(STACK_PUSH), .VEC_ADDR(VEC_ADDR),
    .SERV_HIGH(SERV_HIGH), .SERV_LOW(SERV_LOW));
  core_model core (.clk(CLK), .reset(RESET), .vec_take(VEC_TAKE), .stack_push(STACK_PUSH),
    .vec_addr(VEC_ADDR), .ret_cmd(ret_cmd), .return_instr(RETURN_INSTR), .pc_q(pc));

  task automatic test_done();
    if (err_count == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask

  task automatic rd(input string what, input logic [2:0] a, input logic [7:0] exp);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1 chk8(what, exp, RDATA);
  endtask

  task automatic ev(input logic [4:0] m);
    @(posedge CLK);
    PERIPH_EVENT <= m;
    @(posedge CLK);
    PERIPH_EVENT <= 5'h00;
  endtask

  // Leaves the edge count in n so that latency can be judged afterwards.
  task automatic wait_vec(input logic [15:0] exp);
    n = 0;
    do begin
      @(posedge CLK);
      #1 n = n + 1;
    end while (VEC_TAKE !== 1'b1 && n < 20);
    chk8("vector pulse", 8'h01, {7'h00, VEC_TAKE & STACK_PUSH});
    chk16("vector address", exp, VEC_ADDR);
    @(posedge CLK);
    #1 chk16("core pc", exp, pc);
  endtask

  task automatic no_vec();
    int hits = 0;
    repeat (10) begin
      @(posedge CLK);
      #1 hits += int'(VEC_TAKE !== 1'b0);
    end
    chk8("vector pulses", 8'h00, 8'(hits));
  endtask

  // Returns just after the controller has seen the return, before any re-entry pulse.
  task automatic ret();
    @(posedge CLK);
    ret_cmd <= 1'b1;
    @(posedge CLK);
    ret_cmd <= 1'b0;
    @(posedge CLK);
    #1;
  endtask

  initial begin
    #200000;
    err_count++;
    test_done();
  end

  initial begin
    repeat (4) @(posedge CLK);
    RESET <= 1'b0;
    for (int i = 0; i < 7; i++) rd("reset value", 3'(i), rst_v[i]);
    chk16("reset vector", irq_pkg::VEC_HIGH, VEC_ADDR);
    ev(5'h01);
    rd("flags", 3'h4, 8'h08);
    ev(5'h02);
    wr(3'h2, 8'h08);
    wr(3'h0, 8'h80);
    no_vec();
    wr(3'h0, 8'hC0);
    wait_vec(irq_pkg::VEC_HIGH);
    rd("main ctrl", 3'h0, 8'h40);
    wr(3'h4, 8'h10);
    ret();
    chk8("service levels", 8'h00, {6'h00, SERV_HIGH, SERV_LOW});
    rd("main ctrl", 3'h0, 8'hC0);
    no_vec();
    wr(3'h4, 8'h00);
    wr(3'h0, 8'h80);
    wr(3'h2, 8'h05);
    for (int s = 0; s < 3; s += 2) begin
      @(posedge CLK);
      if (s == 0) EXT_PIN <= 2'h1;
      else CHANGE_PORT <= 4'h1;
      wait_vec(irq_pkg::VEC_HIGH);
      chk8("latency in range", 8'h01, 8'(n >= 3 && n <= 4));
      rd("port value", 3'h7, 8'h10 | 8'(s == 2));
      wr(3'h4, 8'h00);
      ret();
    end
    wr(3'h2, 8'h18);
    wr(3'h3, 8'hF7);
    wr(3'h1, 8'h80);
    wr(3'h0, 8'hC0);
    rd("status", 3'h5, 8'h80);
    ev(5'h01);
    wait_vec(irq_pkg::VEC_LOW);
    rd("main ctrl", 3'h0, 8'h80);
    ev(5'h02);
    wait_vec(irq_pkg::VEC_HIGH);
    rd("status", 3'h5, 8'h83);
    rd("main ctrl", 3'h0, 8'h00);
    wr(3'h4, 8'h00);
    wr(3'h0, 8'hC0);
    ev(5'h01);
    no_vec();
    wr(3'h0, 8'h80);
    ret();
    chk8("service levels", 8'h01, {6'h00, SERV_HIGH, SERV_LOW});
    // The low flag was left set on purpose, so restoring the low enable takes it again.
    ret();
    wait_vec(irq_pkg::VEC_LOW);
    wr(3'h4, 8'h00);
    ret();
    ev(5'h03);
    wait_vec(irq_pkg::VEC_HIGH);
    rd("main ctrl", 3'h0, 8'h40);
    wr(3'h4, 8'h00);
    ret();
    wr(3'h0, 8'h40);
    ev(5'h01);
    no_vec();
    wr(3'h0, 8'hC0);
    wait_vec(irq_pkg::VEC_LOW);
    wr(3'h4, 8'h00);
    ret();
    wr(3'h1, 8'h00);
    ev(5'h01);
    wait_vec(irq_pkg::VEC_HIGH);
    rd("main ctrl", 3'h0, 8'h40);
    wr(3'h5, 8'hFF);
    rd("status", 3'h5, 8'h02);
    wr(3'h4, 8'h00);
    ret();
    // Falling edge selected on both pins: a rising pin 1 must leave its flag alone.
    wr(3'h6, 8'h00);
    wr(3'h2, 8'h02);
    @(posedge CLK);
    EXT_PIN <= 2'h3;
    no_vec();
    rd("flags", 3'h4, 8'h00);
    @(posedge CLK);
    EXT_PIN <= 2'h1;
    wait_vec(irq_pkg::VEC_HIGH);
    chk8("latency in range", 8'h01, 8'(n >= 3 && n <= 4));
    test_done();
  end
endmodule // two_level_interrupt_controller_test
